/* File: src/fractional_value_cfg.svh */
/*
  Constants of the fractional-N control block: register indices, byte
  offsets, field positions, reset values and fixed codes.
  Assumes the including file is compiled after this header only once.
*/
`ifndef FRACTIONAL_VALUE_CFG_SVH
`define FRACTIONAL_VALUE_CFG_SVH

`define IDX_FREQ        3'd0
`define IDX_PHASE       3'd1
`define IDX_MODR        3'd2
`define IDX_FUNC        3'd3
`define IDX_CDIV        3'd4
`define IDX_STATUS      3'd5
`define REG_COUNT       5

`define OFF_FREQ        8'h00
`define OFF_PHASE       8'h04
`define OFF_MODR        8'h08
`define OFF_FUNC        8'h0c
`define OFF_CDIV        8'h10
`define OFF_STATUS      8'h14

`define FREQ_MUX_HI     30
`define FREQ_MUX_LO     27
`define FREQ_INT_HI     26
`define FREQ_INT_LO     15
`define FREQ_FRACTIONAL_VALUE_HI    14
`define FREQ_FRACTIONAL_VALUE_LO    3
`define PHASE_HI        14
`define PHASE_LO        3
`define MODR_CP_HI      27
`define MODR_CP_LO      24
`define MODR_MOD_HI     14
`define MODR_MOD_LO     3
`define FUNC_DITHER     15
`define FUNC_SDRST      14
`define CDIV_MODE_HI    20
`define CDIV_MODE_LO    19
`define CDIV_TMO_HI     18
`define CDIV_TMO_LO     7

`define ST_WIDE         0
`define ST_RESYNC       1
`define ST_OFS_HI       7
`define ST_OFS_LO       4
`define ST_TMR_HI       27
`define ST_TMR_LO       16

`define RST_FREQ        32'h0000_0000
`define RST_PHASE       32'h0000_0001
`define RST_MODR        32'h0000_0012
`define RST_FUNC        32'h0000_0003
`define RST_CDIV        32'h0000_0004

`define MUX_FASTLOCK    4'hc
`define CDIV_FASTLOCK   2'h1
`define CDIV_RESYNC     2'h2
`define CP_BOOST_SHIFT  4
`define MOD_MIN         12'h002
`define SER_BITS        29
`define PFD_DIV_DEF     4
`define LFSR_SEED       21'h1a_5c3e

`endif

/* File: src/fractional_value_pkg.sv */
/*
  Types shared by the fractional-N control block.
  Assumes nothing of its surroundings.
*/
package fractional_value_pkg;

  typedef enum logic [1:0]
  {
    FL_NARROW = 2'b01,
    FL_WIDE   = 2'b10
  } fl_state_type;

  typedef logic [11:0] field12_type;

  typedef logic signed [3:0] sd_offset_type;

endpackage

/* File: src/sd_if.sv */
/*
  Carrier between the control block and its sigma-delta modulator.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface sd_if;
  fractional_value_pkg::field12_type   modulus;
  fractional_value_pkg::field12_type   fractional_value;
  fractional_value_pkg::field12_type   phase;
  logic                    dither_en;
  logic                    restart;
  logic                    step;
  fractional_value_pkg::sd_offset_type offset;

  modport ctrl
  (
    output modulus, fractional_value, phase, dither_en, restart, step,
    input  offset
  );

  modport fractional_modulus
  (
    input  modulus, fractional_value, phase, dither_en, restart, step,
    output offset
  );
endinterface // sd_if

/* File: src/sd_modulator.sv */
/*
  Third-order MASH sigma-delta modulator with programmable modulus.
  Assumes step is a one-cycle pulse at the comparison rate and that the
  fractional value stays below the modulus.
*/
`timescale 1ns/1ps
`include "fractional_value_cfg.svh"
module sd_modulator
(
  input wire logic pclk,
  input wire logic presetn,
  sd_if.fractional_modulus        sd
);

  logic [11:0] acc_q [3];
  logic [11:0] acc_d [3];
  logic [2:0]  car;
  logic        c2_q;
  logic        c3_q;
  logic        c3_qq;
  logic [20:0] lfsr_q;
  logic        dith;

  // Dither enters the last stage, whose carries are differenced twice,
  // so it lengthens the sequence without moving the long-term average.
  assign dith = sd.dither_en & lfsr_q[0]; // see RULE10 see RULE17

  always_comb
  begin
    logic [12:0] sum;
    logic [12:0] inc;
    sum = 13'h0000;
    inc = 13'h0000;
    for (int i = 0; i < 3; i++)
    begin
      if (i == 0)
        inc = {1'b0, sd.fractional_value};
      else if (i == 1)
        inc = {1'b0, acc_d[0]};
      else
        inc = {1'b0, acc_d[1]} + {12'h000, dith};
      sum = {1'b0, acc_q[i]} + inc;
      car[i] = (sum >= {1'b0, sd.modulus}); // see RULE6
      acc_d[i] = car[i] ? 12'(sum - {1'b0, sd.modulus}) : sum[11:0];
    end
  end

  // Accumulators advance once per comparison cycle; a restart reloads the
  // first stage from the phase word and clears the others.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q[0] <= 12'h000;
      acc_q[1] <= 12'h000;
      acc_q[2] <= 12'h000;
    end
    else if (sd.restart)
    begin
      acc_q[0] <= sd.phase; // see RULE11 see RULE12
      acc_q[1] <= 12'h000;
      acc_q[2] <= 12'h000;
    end
    else if (sd.step)
    begin
      acc_q <= acc_d; // see RULE8
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c2_q  <= 1'b0;
      c3_q  <= 1'b0;
      c3_qq <= 1'b0;
    end
    else if (sd.restart)
    begin
      c2_q  <= 1'b0;
      c3_q  <= 1'b0;
      c3_qq <= 1'b0;
    end
    else if (sd.step)
    begin
      c2_q  <= car[1];
      c3_q  <= car[2];
      c3_qq <= c3_q;
    end
  end

  // A 21-bit maximal-length register sets the dithered repeat length.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lfsr_q <= `LFSR_SEED;
    else if (sd.step)
      lfsr_q <= {lfsr_q[19:0], lfsr_q[20] ^ lfsr_q[18]}; // see RULE10
  end

  // Output offset ranges from -3 to +4 around the integer part.
  assign sd.offset = 4'(signed'({3'b000, car[0]}) + signed'({3'b000, car[1]}) - signed'({3'b000, c2_q})
                   + signed'({3'b000, car[2]}) - signed'({2'b00, c3_q, 1'b0}) + signed'({3'b000, c3_qq}));
  // see RULE6 see RULE9 see RULE17

endmodule // sd_modulator

/* File: src/fractional_value_synth_ctrl.sv */
/*
  Digital control of a fractional-N synthesizer: APB register slave,
  three-wire serial loader, comparison-rate enable, sigma-delta
  modulator hookup, fast-lock timer, charge-pump boost and mux pin.
  Assumes pclk is the only clock and the serial pins are asynchronous.
*/
// Function
// RULE1: host loads timeout as duration times comparison rate
// RULE2: fast-lock timing only when divider mode is 01
// RULE3: mux select 1100 routes fast-lock switch to pin
// RULE4: wide mode multiplies charge-pump current by sixteen
// RULE5: fast-lock switch active pulls mux pin to ground
// RULE6: third-order modulator, modulus from 2 to 4095
// RULE7: host keeps modulus at least 50 with dither
// RULE8: modulator advances once per comparison cycle
// RULE9: undithered repeat length follows modulus divisibility
// RULE10: dithered repeat length is two to twenty-first
// RULE11: reset bit 0 restarts modulator on frequency write
// RULE12: phase word is the modulator starting state
// RULE13: frequency write starts timer, boost, switch together
// RULE14: timer expiry restores current and releases switch
// RULE15: divider mode 10 selects phase resync
// RULE16: 29 serial bits latched on load strobe rise
// RULE17: average divide equals integer plus fraction over modulus
// RULE18: timer decrements per comparison cycle, expires at zero
`timescale 1ns/1ps
`include "fractional_value_cfg.svh"
module fractional_value_synth_ctrl
#(
  parameter int unsigned PFD_DIV = `PFD_DIV_DEF
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        load_strobe,
  output logic      [12:0] divide_value,
  output logic      [7:0]  cp_current,
  output logic             mux_output_pin,
  output logic             mux_output_pin_oe_n,
  output logic             resync_enable,
  output logic             fastlock_active
);

  localparam logic [7:0]  DIV_LAST = 8'(PFD_DIV - 1);
  localparam logic [31:0] REG_RST [`REG_COUNT] =
    '{`RST_FREQ, `RST_PHASE, `RST_MODR, `RST_FUNC, `RST_CDIV};

  if (PFD_DIV < 2 || PFD_DIV > 256)
  begin : g_bad_div
    $error("PFD_DIV must lie between 2 and 256");
  end

  logic [7:0]               div_cnt_q;
  logic                     tick_q;
  logic [2:0]               sclk_s_q;
  logic [1:0]               sdat_s_q;
  logic [2:0]               le_s_q;
  logic                     sclk_rise;
  logic                     le_rise;
  logic [`SER_BITS-1:0]     shift_q;
  logic [`SER_BITS-1:0]     ser_word_q;
  logic                     ser_pend_q;
  logic [31:0]              regs_q [`REG_COUNT];
  logic                     acc_phase;
  logic [2:0]               idx;
  logic                     mapped;
  logic                     apb_wr;
  logic                     wr_en;
  logic [2:0]               wr_idx;
  logic [31:0]              wr_data;
  logic                     freq_wr;
  logic [31:0]              rd_val;
  logic [31:0]              prdata_q;
  logic [3:0]               mux_sel;
  logic [11:0]              int_part;
  logic [11:0]              mod_raw;
  logic [3:0]               cp_prog;
  logic [1:0]               cdiv_mode;
  logic [11:0]              tmo;
  logic                     fl_mode;
  fractional_value_pkg::fl_state_type   fl_state_q;
  logic [11:0]              timer_q;
  logic                     wide;
  logic                     wide_next;
  logic [3:0]               mux_sel_next;
  logic [12:0]              divide_value_q;
  logic [7:0]               cp_current_q;
  logic                     mux_oe_n_q;
  logic                     resync_q;

  sd_if sdi ();

  // Comparison-rate enable: one pulse every PFD_DIV cycles of pclk.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_q <= 8'h00;
      tick_q    <= 1'b0;
    end
    else if (div_cnt_q == DIV_LAST)
    begin
      div_cnt_q <= 8'h00;
      tick_q    <= 1'b1;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 8'h01;
      tick_q    <= 1'b0;
    end
  end

  // Serial pins pass two flip-flops; edges are taken after the second.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_s_q <= 3'h0;
      sdat_s_q <= 2'h0;
      le_s_q   <= 3'h0;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[1:0], ser_clk};
      sdat_s_q <= {sdat_s_q[0], ser_data};
      le_s_q   <= {le_s_q[1:0], load_strobe};
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  assign le_rise   = le_s_q[1] & ~le_s_q[2];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shift_q <= '0;
    else if (sclk_rise)
      shift_q <= {shift_q[`SER_BITS-2:0], sdat_s_q[1]}; // see RULE16
  end

  // A loaded word waits here until the register port is free of APB.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ser_pend_q <= 1'b0;
      ser_word_q <= '0;
    end
    else if (le_rise)
    begin
      ser_pend_q <= 1'b1; // see RULE16
      ser_word_q <= shift_q;
    end
    else if (!apb_wr)
    begin
      ser_pend_q <= 1'b0;
    end
  end

  // APB decode: six aligned words, status read-only.
  assign idx    = paddr[4:2];
  assign mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0) && (idx <= `IDX_STATUS);
  assign apb_wr = psel && penable && pwrite && mapped && (idx != `IDX_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // APB wins the write port; a serial word fills DB[28:0] of its latch.
  always_comb
  begin
    wr_en   = 1'b0;
    wr_idx  = 3'h0;
    wr_data = 32'h0000_0000;
    if (apb_wr)
    begin
      wr_en   = 1'b1;
      wr_idx  = idx;
      wr_data = pwdata;
    end
    else if (ser_pend_q && (ser_word_q[2:0] <= `IDX_CDIV))
    begin
      wr_en   = 1'b1; // see RULE16
      wr_idx  = ser_word_q[2:0];
      wr_data = {regs_q[ser_word_q[2:0]][31:`SER_BITS], ser_word_q};
    end
  end

  for (genvar g = 0; g < `REG_COUNT; g++)
  begin : g_reg
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        regs_q[g] <= REG_RST[g];
      else if (wr_en && (wr_idx == 3'(g)))
        regs_q[g] <= wr_data;
    end
  end

  assign freq_wr   = wr_en && (wr_idx == `IDX_FREQ);
  assign mux_sel   = regs_q[`IDX_FREQ][`FREQ_MUX_HI:`FREQ_MUX_LO];
  assign int_part  = regs_q[`IDX_FREQ][`FREQ_INT_HI:`FREQ_INT_LO];
  assign mod_raw   = regs_q[`IDX_MODR][`MODR_MOD_HI:`MODR_MOD_LO];
  assign cp_prog   = regs_q[`IDX_MODR][`MODR_CP_HI:`MODR_CP_LO];
  assign cdiv_mode = regs_q[`IDX_CDIV][`CDIV_MODE_HI:`CDIV_MODE_LO];
  assign tmo       = regs_q[`IDX_CDIV][`CDIV_TMO_HI:`CDIV_TMO_LO]; // see RULE1
  assign fl_mode   = (cdiv_mode == `CDIV_FASTLOCK); // see RULE2
  assign acc_phase = !regs_q[`IDX_FUNC][`FUNC_SDRST];

  // Modulator hookup; moduli below 2 are served as 2.
  assign sdi.modulus   = (mod_raw < `MOD_MIN) ? `MOD_MIN : mod_raw; // see RULE6
  assign sdi.fractional_value      = regs_q[`IDX_FREQ][`FREQ_FRACTIONAL_VALUE_HI:`FREQ_FRACTIONAL_VALUE_LO];
  assign sdi.phase     = regs_q[`IDX_PHASE][`PHASE_HI:`PHASE_LO];
  assign sdi.dither_en = regs_q[`IDX_FUNC][`FUNC_DITHER];
  assign sdi.restart   = freq_wr && acc_phase; // see RULE11
  assign sdi.step      = tick_q; // see RULE8

  sd_modulator u_mod
  (
    .pclk    (pclk),
    .presetn (presetn),
    .sd      (sdi.fractional_modulus)
  );

  // Fast-lock timer: a frequency write in fast-lock mode enters wide mode
  // and loads the timeout; a zero timeout never leaves narrow mode.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_state_q <= fractional_value_pkg::FL_NARROW;
      timer_q    <= 12'h000;
    end
    else if (freq_wr && fl_mode && (tmo != 12'h000))
    begin
      fl_state_q <= fractional_value_pkg::FL_WIDE; // see RULE13
      timer_q    <= tmo;
    end
    else
    begin
      case (fl_state_q)
        fractional_value_pkg::FL_NARROW:
        begin
          timer_q <= 12'h000;
        end
        fractional_value_pkg::FL_WIDE:
        begin
          if (!fl_mode)
          begin
            fl_state_q <= fractional_value_pkg::FL_NARROW; // see RULE2
            timer_q    <= 12'h000;
          end
          else if (tick_q)
          begin
            timer_q <= timer_q - 12'h001; // see RULE18
            if (timer_q == 12'h001)
              fl_state_q <= fractional_value_pkg::FL_NARROW; // see RULE14
          end
        end
        default:
        begin
          fl_state_q <= fractional_value_pkg::FL_NARROW;
          timer_q    <= 12'h000;
        end
      endcase
    end
  end

  assign wide = (fl_state_q == fractional_value_pkg::FL_WIDE);

  // Boost and switch follow the state's next value, so they move on the
  // same edge as the timer and the wide flag.
  assign wide_next    = (freq_wr && fl_mode && (tmo != 12'h000))
                     || (wide && fl_mode && !(tick_q && (timer_q == 12'h001)));
  assign mux_sel_next = freq_wr ? wr_data[`FREQ_MUX_HI:`FREQ_MUX_LO] : mux_sel;

  // Charge-pump code: sixteen times the set value while wide.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cp_current_q <= 8'h00;
    else if (wide_next)
      cp_current_q <= {cp_prog, 4'h0}; // see RULE4 see RULE13
    else
      cp_current_q <= {4'h0, cp_prog}; // see RULE14
  end

  // The mux pin is driven low only as the active fast-lock switch;
  // otherwise it is released.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mux_oe_n_q <= 1'b1;
    else
      mux_oe_n_q <= !((mux_sel_next == `MUX_FASTLOCK) && wide_next); // see RULE3 see RULE5
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      resync_q <= 1'b0;
    else
      resync_q <= (cdiv_mode == `CDIV_RESYNC); // see RULE15
  end

  // Instantaneous divide value: integer part plus modulator offset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divide_value_q <= 13'h0000;
    else
      divide_value_q <= 13'({1'b0, int_part} + {{9{sdi.offset[3]}}, sdi.offset}); // see RULE17
  end

  // Read mux; data is captured in the setup phase for a zero-wait answer.
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (mapped)
    begin
      if (idx == `IDX_STATUS)
      begin
        rd_val[`ST_WIDE]              = wide;
        rd_val[`ST_RESYNC]            = resync_q;
        rd_val[`ST_OFS_HI:`ST_OFS_LO] = sdi.offset;
        rd_val[`ST_TMR_HI:`ST_TMR_LO] = timer_q;
      end
      else
      begin
        rd_val = regs_q[idx];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_q <= rd_val;
  end

  assign prdata              = prdata_q;
  assign divide_value        = divide_value_q;
  assign cp_current          = cp_current_q;
  assign mux_output_pin      = 1'b0;
  assign mux_output_pin_oe_n = mux_oe_n_q;
  assign resync_enable       = resync_q;
  assign fastlock_active     = wide;

endmodule // fractional_value_synth_ctrl

/* File: bench/fractional_value_synth_ctrl_asserts.sv */
/* Port-level checker for fractional_value_synth_ctrl.
   Assumes it is bound into every instance and sees only that module's ports. */
`timescale 1ns/1ps
module fractional_value_synth_ctrl_asserts
#(
  parameter int unsigned PFD_DIV = 4
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ser_clk,
  input wire logic        ser_data,
  input wire logic        load_strobe,
  input wire logic [12:0] divide_value,
  input wire logic [7:0]  cp_current,
  input wire logic        mux_output_pin,
  input wire logic        mux_output_pin_oe_n,
  input wire logic        resync_enable,
  input wire logic        fastlock_active
);
  localparam int FL_MAX = 4096 * PFD_DIV + 2;
  logic        ls_q;
  logic [3:0]  ls_cnt_q;
  logic [19:0] fl_cnt_q;
  logic        fwr;
  logic        cwr;

  assign fwr = psel && penable && pwrite && paddr == 8'h00;
  assign cwr = psel && penable && pwrite && paddr == 8'h10;

  // A serial load lands a few cycles after the strobe; this window covers it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ls_q     <= 1'b0;
      ls_cnt_q <= 4'h0;
    end
    else
    begin
      ls_q     <= load_strobe;
      ls_cnt_q <= (load_strobe && !ls_q) ? 4'hc : ((ls_cnt_q != 4'h0) ? ls_cnt_q - 4'h1 : 4'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fl_cnt_q <= 20'h0;
    else
      fl_cnt_q <= (!fastlock_active || fwr) ? 20'h0 : fl_cnt_q + 20'h1;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PIN_LOW: assert property (mux_output_pin == 1'b0)
    else $error("mux pin driven high");
  AST_CP_NARROW: assert property (!fastlock_active |-> cp_current[7:4] == 4'h0)
    else $error("current boosted outside wide mode");
  AST_CP_WIDE: assert property (fastlock_active |-> cp_current[3:0] == 4'h0)
    else $error("current not a multiple of sixteen in wide mode");
  AST_CP_BOOST: assert property ($rose(fastlock_active) |-> cp_current == {$past(cp_current[3:0]), 4'h0})
    else $error("boost is not sixteen times the set current");
  AST_OE_NARROW: assert property (!fastlock_active |-> mux_output_pin_oe_n)
    else $error("switch closed outside wide mode");
  AST_FL_CAUSE: assert property ($rose(fastlock_active) |-> $past(fwr) || $past(fwr, 2) || ls_cnt_q != 4'h0)
    else $error("wide mode entered without a frequency write");
  AST_FL_BOUND: assert property (fl_cnt_q <= FL_MAX)
    else $error("wide mode outlasts the largest timeout");
  AST_RESYNC: assert property ($changed(resync_enable) |-> $past(cwr) || $past(cwr, 2) || $past(cwr, 3)
                               || ls_cnt_q != 4'h0)
    else $error("resync enable changed without a divider write");

  COV_FL_RISE: cover property ($rose(fastlock_active));
  COV_FL_FALL: cover property ($fell(fastlock_active));
  COV_SWITCH: cover property (!mux_output_pin_oe_n);
  COV_RESYNC: cover property ($rose(resync_enable));
endmodule // fractional_value_synth_ctrl_asserts

bind fractional_value_synth_ctrl fractional_value_synth_ctrl_asserts #(.PFD_DIV(PFD_DIV)) u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe),
  .divide_value(divide_value), .cp_current(cp_current), .mux_output_pin(mux_output_pin),
  .mux_output_pin_oe_n(mux_output_pin_oe_n), .resync_enable(resync_enable),
  .fastlock_active(fastlock_active)
);

/* File: bench/host_serial_model.sv */
/* Behavioural host that loads 29-bit words over the three-wire port.
   Assumes clk is the bench clock; the serial clock stays low five cycles per bit, every other serial phase lasts four. */
`timescale 1ns/1ps
module host_serial_model
(
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_strobe
);
  initial
  begin
    ser_clk     = 1'b0;
    ser_data    = 1'b0;
    load_strobe = 1'b0;
  end

  // The clock stands low between words and released data shows the inverse.
  task automatic send(input logic [28:0] word);
    int i;
    for (i = 28; i >= 0; i--)
    begin
      @(posedge clk);
      ser_data <= word[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ser_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    ser_data    <= ~word[0];
    load_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    load_strobe <= 1'b0;
  endtask
endmodule // host_serial_model

/* File: bench/fractional_modulator_fastlock_ctrl_test.sv */
/* Self-checking bench for the fractional-N control block.
   Assumes the design, the checker and the host model are compiled before it. */
`timescale 1ns/1ps
`include "fractional_value_cfg.svh"
module fractional_modulator_fastlock_ctrl_test;
  localparam int unsigned PD = 2;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, s;
  logic        pready, pslverr, err, ok;
  logic        ser_clk, ser_data, load_strobe;
  logic [12:0] divide_value;
  logic [7:0]  cp_current;
  logic        mux_output_pin, mux_output_pin_oe_n, resync_enable, fastlock_active;
  logic [12:0] smp [720];
  logic [31:0] rstv [5] = '{`RST_FREQ, `RST_PHASE, `RST_MODR, `RST_FUNC, `RST_CDIV};
  int          mods [4] = '{4, 3, 6, 5};
  int          fails, n_compared, i, j, n, l, m;

  fractional_value_synth_ctrl #(.PFD_DIV(PD)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe),
    .divide_value(divide_value), .cp_current(cp_current), .mux_output_pin(mux_output_pin),
    .mux_output_pin_oe_n(mux_output_pin_oe_n), .resync_enable(resync_enable),
    .fastlock_active(fastlock_active)
  );

  host_serial_model host (.clk(pclk), .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));

  always #10 pclk = ~pclk;

  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 100);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 100)
    begin
      fails++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask

  task automatic waitfl;
    int k;
    k = 0;
    while (fastlock_active !== 1'b1 && k < 100)
    begin
      @(posedge pclk);
      k++;
    end
    if (k == 100)
    begin
      fails++;
      tally_and_finish();
    end
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    n_compared = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check("reset value", rstv[i], rd);
    end
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped error", 1'b1, err);
    check("unmapped data", 32'h0, rd);
    for (m = 0; m < 4; m++)
    begin
      if (m == 1)
        continue;
      apb(1'b1, `OFF_CDIV, (32'(m) << 19) | 32'h300);
      apb(1'b1, `OFF_FREQ, 32'h0032_0000);
      repeat (4) @(posedge pclk);
      check("resync mode", m == 2, resync_enable);
      check("no fast lock", 1'b0, fastlock_active);
    end
    // Timeout of 6 ticks stands for a wide time of 12 cycles at this tick rate.
    apb(1'b1, `OFF_MODR, 32'h0500_0020);
    apb(1'b1, `OFF_CDIV, 32'h0008_0300);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, `OFF_FREQ, i ? 32'h0032_0000 : 32'h6032_0000);
      waitfl();
      check("boost with timer", 8'h50, cp_current);
      n = 0;
      while (fastlock_active === 1'b1 && n < 20000)
      begin
        @(posedge pclk);
        n++;
        if (n == 2)
        begin
          check("boosted current", 8'h50, cp_current);
          check("switch", i, mux_output_pin_oe_n);
          check("pin level", 1'b0, mux_output_pin);
        end
      end
      check("wide time", 1'b1, n >= 6 * PD - 1 && n <= 6 * PD);
      repeat (2) @(posedge pclk);
      check("restored current", 8'h05, cp_current);
      check("released switch", 1'b1, mux_output_pin_oe_n);
    end
    apb(1'b1, `OFF_CDIV, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      m = mods[i];
      l = PD * m * ((m % 6 == 0) ? 6 : (m % 2 == 0) ? 2 : (m % 3 == 0) ? 3 : 1);
      apb(1'b1, `OFF_MODR, 32'(m) << 3);
      apb(1'b1, `OFF_FREQ, 32'h0032_0008);
      repeat (16) @(posedge pclk);
      s = 32'h0;
      ok = 1'b1;
      for (j = 0; j < 720; j++)
      begin
        smp[j] = divide_value;
        s = s + {19'h0, divide_value};
        @(posedge pclk);
      end
      for (j = 0; j + l < 720; j++)
        if (smp[j] !== smp[j + l])
          ok = 1'b0;
      check("average divide", 32'(720 * 100 + 720 / m), s);
      check("repeat length", 1'b1, ok);
    end
    // Dither with a modulus of 50 must break the undithered repeat of 100 ticks.
    apb(1'b1, `OFF_FUNC, 32'h0000_8000);
    apb(1'b1, `OFF_MODR, 32'h0000_0190);
    apb(1'b1, `OFF_FREQ, 32'h0032_0008);
    repeat (16) @(posedge pclk);
    for (j = 0; j < 720; j++)
    begin
      smp[j] = divide_value;
      @(posedge pclk);
    end
    ok = 1'b1;
    for (j = 0; j + 100 * PD < 720; j++)
      if (smp[j] !== smp[j + 100 * PD])
        ok = 1'b0;
    check("dithered repeat", 1'b0, ok);
    host.send({14'h0, 12'h2a5, 3'h1});
    repeat (8) @(posedge pclk);
    apb(1'b0, `OFF_PHASE, 32'h0);
    check("serial load", 32'h0000_1529, rd);
    host.send({14'h0, 12'h0ff, 3'h7});
    repeat (8) @(posedge pclk);
    apb(1'b0, `OFF_PHASE, 32'h0);
    check("dropped word", 32'h0000_1529, rd);
    tally_and_finish();
  end
endmodule // fractional_modulator_fastlock_ctrl_test
